// ===== rtl/hvcr_map.svh
`ifndef HVCR_MAP_SVH
`define HVCR_MAP_SVH

// ----------------------------------------
// Indirect commands
// ----------------------------------------
`define HVCR_CMD_RD_PRI 8'h00
`define HVCR_CMD_RD_SEC 8'h01
`define HVCR_CMD_RD_MON 8'h03
`define HVCR_CMD_WR_PRI 8'h08
`define HVCR_CMD_WR_SEC 8'h09

// ----------------------------------------
// Field positions
// ----------------------------------------
`define HVCR_P_THERM_DIS 7
`define HVCR_P_OSC_EN 6
`define HVCR_P_WAKE 4
`define HVCR_P_PSM_EN 3
`define HVCR_P_LVF_EN 2
`define HVCR_S_ATTEN_EN 7
`define HVCR_S_TMON_EN 6
`define HVCR_MON_LVF 3
`define HVCR_STAT_TX_OK 2
`define HVCR_STAT_RD_OK 1
`define HVCR_STAT_BUSY 0
`define HVCR_LIN_OFF 2'h0
`define HVCR_LIN_ON 2'h2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define HVCR_CFG_RESET 8'h00
`define HVCR_CLK_NS 40
`define HVCR_LAT_NS 10000
`define HVCR_OSC_START_NS 70000
`define HVCR_LAT_CYC ((`HVCR_LAT_NS + `HVCR_CLK_NS - 1) / `HVCR_CLK_NS)
`define HVCR_OSC_CYC ((`HVCR_OSC_START_NS + `HVCR_CLK_NS - 1) / `HVCR_CLK_NS)
`endif

// ===== rtl/hvcr_pkg.sv
package hvcr_pkg;
  typedef logic [7:0] hvcr_byte_t;
  typedef logic [11:0] hvcr_data_t;
  typedef enum logic {HVCR_IDLE, HVCR_BUSY} hvcr_state_t;
endpackage

// ===== rtl/hvcr_regs.sv
`include "hvcr_map.svh"
module hvcr_regs #(
  parameter int LAT_CYC = `HVCR_LAT_CYC,
  parameter int OSC_CYC = `HVCR_OSC_CYC
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic cmd_wr, // write strobe, command register
  input wire hvcr_pkg::hvcr_byte_t cmd_wdata, // command byte
  output hvcr_pkg::hvcr_byte_t cmd_rdata, // busy and result status
  input wire logic dat_wr, // write strobe, data register
  input wire hvcr_pkg::hvcr_byte_t dat_wdata, // data low byte
  output hvcr_pkg::hvcr_data_t dat_rdata, // command nibble and data
  input wire logic thermal_event, // wake driver over-temperature pin
  input wire logic supply_low, // supply below 6.0 V pin
  input wire logic dvdd_low, // digital supply below 2.1 V pin
  input wire logic hv_irq_en, // interrupt source enable
  output logic hv_interrupt, // supply monitor interrupt
  output logic wake_pin_o, // wake pin drive value
  output logic wake_pin_oe, // wake pin drive enable
  output logic osc_en, // precision oscillator power
  output logic osc_ready, // oscillator start-up elapsed
  output logic psm_en, // supply monitor power
  output logic lin_drv_en, // bus transceiver driver on
  output logic atten_en, // attenuator and buffer on
  output logic tmon_en, // temperature monitor on
  output logic tmon_to_adc // temperature channel input select
);
  import hvcr_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  hvcr_state_t state;
  hvcr_byte_t hv_config_primary;
  hvcr_byte_t hv_config_secondary;
  hvcr_byte_t hv_data_reg;
  hvcr_byte_t cmd_latched;
  logic [15:0] lat_cnt;
  logic [15:0] osc_cnt;
  logic rd_ok;
  logic tx_ok;
  logic wake_shut;
  logic low_flag;
  logic thermal_s;
  logic supply_low_s;
  logic dvdd_low_s;

  hvcr_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in({thermal_event, supply_low, dvdd_low}),
    .sync_out({thermal_s, supply_low_s, dvdd_low_s})
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire busy = (state == HVCR_BUSY);
  wire accept = cmd_wr && !busy;
  wire done = busy && (lat_cnt == 16'h0000);
  wire is_wr_pri = (cmd_latched == `HVCR_CMD_WR_PRI);
  wire is_wr_sec = (cmd_latched == `HVCR_CMD_WR_SEC);
  wire is_rd_pri = (cmd_latched == `HVCR_CMD_RD_PRI);
  wire is_rd_sec = (cmd_latched == `HVCR_CMD_RD_SEC);
  wire is_rd_mon = (cmd_latched == `HVCR_CMD_RD_MON);
  wire is_rd = is_rd_pri || is_rd_sec || is_rd_mon;
  wire is_wr = is_wr_pri || is_wr_sec;
  wire [7:0] hv_monitor_reg = {4'h0, low_flag, 3'h0};
  wire [7:0] rd_value = is_rd_pri ? hv_config_primary :
                        is_rd_sec ? hv_config_secondary : hv_monitor_reg;
  wire wake_req = hv_config_primary[`HVCR_P_WAKE];
  wire shut_trip = thermal_s && wake_req && !hv_config_primary[`HVCR_P_THERM_DIS];

  assign cmd_rdata = {5'h00, tx_ok, rd_ok, busy};
  assign dat_rdata = {cmd_latched[3:0], hv_data_reg};

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  // busy for the interface latency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= HVCR_IDLE;
      lat_cnt <= 16'h0000;
      cmd_latched <= 8'h00;
    end else begin
      case (state)
        HVCR_IDLE: begin
          if (accept) begin
            state <= HVCR_BUSY;
            cmd_latched <= cmd_wdata;
            lat_cnt <= 16'(LAT_CYC - 1);
          end
        end
        HVCR_BUSY: begin
          if (done) begin
            state <= HVCR_IDLE;
          end else begin
            lat_cnt <= lat_cnt - 16'h0001;
          end
        end
        default: state <= HVCR_IDLE;
      endcase
    end
  end

  // Status valid once busy clears; unknown command fails both
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ok <= 1'b0;
      tx_ok <= 1'b0;
    end else if (accept) begin
      rd_ok <= 1'b0;
      tx_ok <= 1'b0;
    end else if (done) begin
      rd_ok <= is_rd;
      tx_ok <= is_wr;
    end
  end

  // Data register; software writes ignored while busy so a read result cannot be torn
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hv_data_reg <= 8'h00;
    end else if (done && is_rd) begin
      hv_data_reg <= rd_value;
    end else if (dat_wr && !busy) begin
      hv_data_reg <= dat_wdata;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // reset to zero, written only by command
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hv_config_primary <= `HVCR_CFG_RESET;
      hv_config_secondary <= `HVCR_CFG_RESET;
    end else if (done) begin
      if (is_wr_pri) hv_config_primary <= hv_data_reg;
      if (is_wr_sec) hv_config_secondary <= hv_data_reg;
    end
  end

  // ----------------------------------------
  // High-voltage controls
  // ----------------------------------------
  // latched shutdown, rearmed by rewriting primary
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_shut <= 1'b0;
    end else if (shut_trip) begin
      wake_shut <= 1'b1;
    end else if (done && is_wr_pri) begin
      wake_shut <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt <= 16'h0000;
      osc_ready <= 1'b0;
    end else if (!hv_config_primary[`HVCR_P_OSC_EN]) begin
      osc_cnt <= 16'h0000;
      osc_ready <= 1'b0;
    end else if (osc_cnt == 16'(OSC_CYC - 1)) begin
      osc_ready <= 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_flag <= 1'b0;
    end else if (dvdd_low_s && hv_config_primary[`HVCR_P_LVF_EN]) begin
      low_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hv_interrupt <= 1'b0;
      wake_pin_o <= 1'b0;
      wake_pin_oe <= 1'b0;
      osc_en <= 1'b0;
      psm_en <= 1'b0;
      lin_drv_en <= 1'b0;
      atten_en <= 1'b0;
      tmon_en <= 1'b0;
      tmon_to_adc <= 1'b0;
    end else begin
      hv_interrupt <= hv_config_primary[`HVCR_P_PSM_EN] && hv_irq_en && supply_low_s;
      // drive high or release to pull-down
      wake_pin_o <= 1'b1;
      wake_pin_oe <= wake_req && !wake_shut && !shut_trip;
      osc_en <= hv_config_primary[`HVCR_P_OSC_EN];
      psm_en <= hv_config_primary[`HVCR_P_PSM_EN];
      // reserved codes leave the driver off
      lin_drv_en <= (hv_config_primary[1:0] == `HVCR_LIN_ON);
      atten_en <= hv_config_secondary[`HVCR_S_ATTEN_EN];
      tmon_en <= hv_config_secondary[`HVCR_S_TMON_EN];
      tmon_to_adc <= hv_config_secondary[`HVCR_S_TMON_EN];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Tracks the module parameter, so a latency shortened down to 8 cycles is still checked
  localparam int A_GAP = LAT_CYC - 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_accept;
    cmd_wr && !busy;
  endsequence
  sequence s_complete;
    busy [*8] ##A_GAP busy ##1 !busy;
  endsequence

  property p_cmd_latency;
    s_accept |=> s_complete;
  endproperty
  a_cmd_latency: assert property (p_cmd_latency) else $error("busy length wrong");

  property p_wr_primary;
    done && is_wr_pri |=> hv_config_primary == $past(hv_data_reg) && tx_ok && !rd_ok;
  endproperty
  a_wr_primary: assert property (p_wr_primary) else $error("primary write lost");

  property p_rd_secondary;
    done && is_rd_sec |=> dat_rdata[7:0] == $past(hv_config_secondary) && rd_ok;
  endproperty
  a_rd_secondary: assert property (p_rd_secondary) else $error("read value wrong");

  property p_cfg_stable;
    !done |=> $stable(hv_config_primary) && $stable(hv_config_secondary);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed uncommanded");

  property p_thermal;
    shut_trip |=> !wake_pin_oe ##1 !wake_pin_oe;
  endproperty
  a_thermal: assert property (p_thermal) else $error("wake not shut down");

  property p_wake;
    !hv_config_primary[`HVCR_P_WAKE] |=> !wake_pin_oe;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pin not released");

  property p_osc;
    $rose(osc_en) |-> !osc_ready [*8];
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator ready too early");

  property p_psm;
    hv_config_primary[`HVCR_P_PSM_EN] && hv_irq_en && supply_low_s |=> hv_interrupt;
  endproperty
  a_psm: assert property (p_psm) else $error("supply interrupt missing");

  property p_lvf;
    low_flag |=> low_flag;
  endproperty
  a_lvf: assert property (p_lvf) else $error("low flag not sticky");

  property p_lin;
    hv_config_primary[0] |=> !lin_drv_en;
  endproperty
  a_lin: assert property (p_lin) else $error("driver on in reserved mode");

  property p_atten;
    atten_en |-> $past(hv_config_secondary[`HVCR_S_ATTEN_EN]) && tmon_en == tmon_to_adc;
  endproperty
  a_atten: assert property (p_atten) else $error("attenuator or monitor route wrong");
endmodule

// ===== rtl/hvcr_sync.sv
module hvcr_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [W-1:0] async_in, // pins from outside
  output logic [W-1:0] sync_out // filtered level
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  wire [W-1:0] agree = ~(ff2 ^ ff3);

  // Only ff2 reads ff1; a change counts once ff2 and ff3 agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      sync_out <= '0;
    end else begin
      ff1 <= async_in;
      ff2 <= ff1;
      ff3 <= ff2;
      sync_out <= (agree & ff3) | (~agree & sync_out);
    end
  end
endmodule

// ===== test/hvcr_hv_model.sv
module hvcr_hv_model (
  input wire logic therm_req, // overheat stimulus
  input wire logic vdd_drop, // battery sag stimulus
  input wire logic dvdd_drop, // digital supply sag stimulus
  input wire logic wake_pin_o, // wake drive value
  input wire logic wake_pin_oe, // wake drive enable
  output logic thermal_event, // overheat pin
  output logic supply_low, // supply below 6.0 V pin
  output logic dvdd_low, // digital supply below 2.1 V pin
  output logic wake_level // level seen on the wake pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign wake_level = wake_pin_oe ? wake_pin_o : 1'b0;
  assign thermal_event = therm_req & wake_level;
  assign supply_low = vdd_drop;
  assign dvdd_low = dvdd_drop;
endmodule

// ===== test/tb_top.sv
`include "hvcr_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hvcr_pkg::*;
  typedef struct {logic sec; hvcr_byte_t data; logic [6:0] outs;} hvcr_row_t;
  logic clk, rst_b, cmd_wr, dat_wr, hv_irq_en, therm_req, vdd_drop, dvdd_drop;
  hvcr_byte_t cmd_wdata, cmd_rdata, dat_wdata;
  hvcr_data_t dat_rdata;
  logic thermal_event, supply_low, dvdd_low, hv_interrupt, wake_pin_o, wake_pin_oe;
  logic wake_level, osc_en, osc_ready, psm_en, lin_drv_en, atten_en, tmon_en, tmon_to_adc;
  int n_errors = 0;
  int check_count = 0;
  // Outputs: wake level, osc, monitor, transceiver, attenuator, temp monitor, temp select
  hvcr_row_t rows [8] = '{'{1'b0, 8'h40, 7'h20}, '{1'b0, 8'h08, 7'h10},
    '{1'b0, 8'h02, 7'h08}, '{1'b0, 8'h01, 7'h00}, '{1'b0, 8'h03, 7'h00},
    '{1'b0, 8'h10, 7'h40}, '{1'b1, 8'h80, 7'h44}, '{1'b1, 8'h40, 7'h43}};

  hvcr_regs u_dut (.clk, .rst_b, .cmd_wr, .cmd_wdata, .cmd_rdata, .dat_wr, .dat_wdata,
    .dat_rdata, .thermal_event, .supply_low, .dvdd_low, .hv_irq_en, .hv_interrupt,
    .wake_pin_o, .wake_pin_oe, .osc_en, .osc_ready, .psm_en, .lin_drv_en, .atten_en,
    .tmon_en, .tmon_to_adc);
  hvcr_hv_model u_hv (.therm_req, .vdd_drop, .dvdd_drop, .wake_pin_o, .wake_pin_oe,
    .thermal_event, .supply_low, .dvdd_low, .wake_level);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("Errors %0d, checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic put(input hvcr_byte_t d);
    @(negedge clk);
    dat_wr = 1'b1;
    dat_wdata = d;
    @(negedge clk);
    dat_wr = 1'b0;
  endtask

  task automatic pulse_cmd(input hvcr_byte_t c);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_wdata = c;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask

  // Bounded poll of the busy bit
  task automatic wait_idle;
    int i;
    i = 0;
    while (cmd_rdata[0] !== 1'b0 && i < 400) begin
      @(negedge clk);
      i++;
    end
    chk("busy_done", 12'h000, {11'h000, cmd_rdata[0]});
  endtask

  task automatic send(input hvcr_byte_t c);
    pulse_cmd(c);
    wait_idle();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    cmd_wr = 1'b0;
    dat_wr = 1'b0;
    cmd_wdata = 8'h00;
    dat_wdata = 8'h00;
    hv_irq_en = 1'b0;
    therm_req = 1'b0;
    vdd_drop = 1'b0;
    dvdd_drop = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    foreach (rows[k]) begin
      put(rows[k].data);
      send(rows[k].sec ? `HVCR_CMD_WR_SEC : `HVCR_CMD_WR_PRI);
      chk("write_status", 12'h004, {4'h0, cmd_rdata});
      repeat (2) @(negedge clk);
      chk("controls", {5'h00, rows[k].outs}, {5'h00, wake_level, osc_en, psm_en, lin_drv_en,
        atten_en, tmon_en, tmon_to_adc});
      send(rows[k].sec ? `HVCR_CMD_RD_SEC : `HVCR_CMD_RD_PRI);
      chk("read_status", 12'h002, {4'h0, cmd_rdata});
      chk("readback", {3'h0, rows[k].sec, rows[k].data}, dat_rdata);
    end
    // Mid-run reset
    @(negedge clk);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk("reset_outputs", 12'h000, {2'h0, wake_pin_o, wake_pin_oe, osc_en, osc_ready, psm_en,
      lin_drv_en, atten_en, tmon_en, tmon_to_adc, hv_interrupt});
    chk("reset_status", 12'h000, {4'h0, cmd_rdata});
    rst_b = 1'b1;
    send(`HVCR_CMD_RD_PRI);
    chk("reset_primary", 12'h000, dat_rdata);
    send(`HVCR_CMD_RD_SEC);
    chk("reset_secondary", 12'h100, dat_rdata);
    // Data and command while busy must be dropped
    put(8'h15);
    pulse_cmd(`HVCR_CMD_WR_PRI);
    repeat (5) @(negedge clk);
    put(8'hAA);
    pulse_cmd(`HVCR_CMD_WR_SEC);
    wait_idle();
    chk("busy_refusal", 12'h815, dat_rdata);
    send(`HVCR_CMD_RD_SEC);
    chk("secondary_kept", 12'h100, dat_rdata);
    send(8'h05);
    chk("unknown_status", 12'h000, {4'h0, cmd_rdata});
    send(`HVCR_CMD_RD_PRI);
    chk("unknown_no_effect", 12'h015, dat_rdata);
    // Oscillator start-up span
    put(8'h40);
    send(`HVCR_CMD_WR_PRI);
    repeat (2) @(negedge clk);
    chk("osc_early", 12'h000, {11'h000, osc_ready});
    repeat (1743) @(negedge clk);
    chk("osc_not_yet", 12'h000, {11'h000, osc_ready});
    repeat (10) @(negedge clk);
    chk("osc_ready", 12'h001, {11'h000, osc_ready});
    // Supply monitor interrupt and its enable
    put(8'h08);
    send(`HVCR_CMD_WR_PRI);
    hv_irq_en = 1'b1;
    vdd_drop = 1'b1;
    repeat (8) @(negedge clk);
    chk("supply_irq", 12'h001, {11'h000, hv_interrupt});
    hv_irq_en = 1'b0;
    repeat (2) @(negedge clk);
    chk("supply_irq_masked", 12'h000, {11'h000, hv_interrupt});
    vdd_drop = 1'b0;
    // Sticky low-voltage flag
    put(8'h04);
    send(`HVCR_CMD_WR_PRI);
    dvdd_drop = 1'b1;
    repeat (8) @(negedge clk);
    dvdd_drop = 1'b0;
    repeat (8) @(negedge clk);
    send(`HVCR_CMD_RD_MON);
    chk("low_voltage_flag", 12'h308, dat_rdata);
    // Thermal shutdown, then shutdown disabled
    put(8'h10);
    send(`HVCR_CMD_WR_PRI);
    therm_req = 1'b1;
    repeat (10) @(negedge clk);
    chk("thermal_shutdown", 12'h000, {11'h000, wake_pin_oe});
    therm_req = 1'b0;
    put(8'h90);
    send(`HVCR_CMD_WR_PRI);
    repeat (2) @(negedge clk);
    therm_req = 1'b1;
    repeat (10) @(negedge clk);
    chk("thermal_kept", 12'h001, {11'h000, wake_pin_oe});
    therm_req = 1'b0;
    end_of_test();
  end
endmodule
